// ==== core/pcf_core.sv ====
// Next-fetch pointer and condition flag register with APB access.
// Assumes CPU control strobes come from logic on I_SYS_CLK and memory
// answers vector reads through a same-clock valid/data pair.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module pcf_core
  import pcf_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_ARST_N,
  // APB slave.
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Reset vector read port.
  output logic             O_VEC_REQ,
  output logic      [15:0] O_VEC_ADDR,
  input  wire logic        I_VEC_VALID,
  input  wire logic [7:0]  I_VEC_DATA,
  // Fetch pointer control.
  input  wire logic        I_FETCH,
  input  wire logic        I_PTR_LOAD,
  input  wire logic [15:0] I_PTR_TARGET,
  output logic      [15:0] O_NEXT_FETCH_POINTER,
  output logic             O_CPU_RUN,
  // ALU operation.
  input  wire logic [3:0]  I_ALU_OP,
  input  wire logic [7:0]  I_ALU_A,
  input  wire logic [7:0]  I_ALU_B,
  input  wire logic [15:0] I_ALU_WIDE,
  input  wire logic        I_ALU_CARRY,
  output logic      [7:0]  O_ALU_RESULT,
  // Flag transfers and interrupt control.
  input  wire logic        I_FLAGS_WE,
  input  wire logic [7:0]  I_FLAGS_WDATA,
  input  wire logic        I_MASK_IRQ_INSTR,
  input  wire logic        I_UNMASK_IRQ_INSTR,
  input  wire logic        I_REGS_SAVED,
  input  wire logic        I_BOUNDARY,
  input  wire logic        I_IRQ_PENDING,
  output logic             O_IRQ_ACCEPT,
  output logic      [7:0]  O_CONDITION_FLAGS,
  // Signed branch conditions.
  output logic             O_BRANCH_SIGNED_GREATER,
  output logic             O_BRANCH_SIGNED_GREATER_EQUAL,
  output logic             O_BRANCH_SIGNED_LESS_EQUAL,
  output logic             O_BRANCH_SIGNED_LESS
);

  pcf_core_st_t cur;
  pcf_core_st_t nxt;

  logic        apb_setup;
  logic        apb_access;
  logic        hit_ptr;
  logic        hit_flags;
  logic        hit_status;
  logic        apb_ptr_wr;
  logic        apb_flags_wr;
  logic        running;
  logic [7:0]  calc_res;
  logic [7:0]  calc_val;
  logic [7:0]  calc_upd;
  logic        mask_now;
  logic [7:0]  wr_flags;

  pcf_flag_calc u_calc (
    .i_op    (I_ALU_OP),
    .i_a     (I_ALU_A),
    .i_b     (I_ALU_B),
    .i_wide  (I_ALU_WIDE),
    .i_carry (I_ALU_CARRY),
    .i_flags (cur.flags),
    .o_res   (calc_res),
    .o_val   (calc_val),
    .o_upd   (calc_upd)
  );

  // Address decoding for the three registers.
  always_comb
  begin
    hit_ptr    = 1'b0;
    hit_flags  = 1'b0;
    hit_status = 1'b0;
    if (I_PADDR == PCF_OFS_PTR)
    begin
      hit_ptr = 1'b1;
    end
    else if (I_PADDR == PCF_OFS_FLAGS)
    begin
      hit_flags = 1'b1;
    end
    else if (I_PADDR == PCF_OFS_STATUS)
    begin
      hit_status = 1'b1;
    end
  end

  assign apb_setup    = I_PSEL && !I_PENABLE;
  assign apb_access   = I_PSEL && I_PENABLE;
  assign apb_ptr_wr   = apb_access && I_PWRITE && hit_ptr;
  assign apb_flags_wr = apb_access && I_PWRITE && hit_flags;
  assign running      = (cur.state == PCF_ST_RUN);
  assign mask_now     = cur.flags[PCF_FLG_I];
  // A CPU flag transfer takes precedence over a debug write in the same cycle.
  assign wr_flags     = I_FLAGS_WE ? I_FLAGS_WDATA : I_PWDATA[7:0];

  always_comb
  begin
    nxt = cur;
    // Reset vector fetch, then normal pointer behaviour.
    case (cur.state)
      PCF_ST_VEC_HI:
      begin
        if (I_VEC_VALID)
        begin
          nxt.vec_hi = I_VEC_DATA; // RL5
          nxt.state  = PCF_ST_VEC_LO;
        end
      end
      PCF_ST_VEC_LO:
      begin
        if (I_VEC_VALID)
        begin
          nxt.ptr   = {cur.vec_hi, I_VEC_DATA}; // RL4 RL5
          nxt.state = PCF_ST_RUN;
        end
      end
      PCF_ST_RUN:
      begin
        if (I_PTR_LOAD)
        begin
          nxt.ptr = I_PTR_TARGET; // RL3
        end
        else if (apb_ptr_wr)
        begin
          nxt.ptr = I_PWDATA[15:0]; // RL3
        end
        else if (I_FETCH)
        begin
          nxt.ptr = cur.ptr + 16'h0001; // RL1 RL2
        end
      end
      default:
      begin
        nxt.state = PCF_ST_VEC_HI;
      end
    endcase

    // Flag updates: ALU results, then explicit transfers.
    nxt.flags = (cur.flags & ~calc_upd) | (calc_val & calc_upd);
    if (calc_upd != 8'h00)
    begin
      nxt.alu_res = calc_res;
    end
    if (I_FLAGS_WE || apb_flags_wr)
    begin
      nxt.flags = wr_flags;
    end
    if (I_UNMASK_IRQ_INSTR)
    begin
      nxt.flags[PCF_FLG_I] = 1'b0;
    end
    if (I_MASK_IRQ_INSTR || I_REGS_SAVED)
    begin
      nxt.flags[PCF_FLG_I] = 1'b1; // RL11
    end
    nxt.flags = nxt.flags | PCF_FLG_ONES; // RL6

    // Interrupt hold-off across the boundary after the mask is cleared.
    if (I_BOUNDARY)
    begin
      nxt.inhibit = 1'b0;
    end
    if (mask_now && !nxt.flags[PCF_FLG_I])
    begin
      nxt.inhibit = 1'b1; // RL12
    end

    // Read data is captured in the setup phase and shown in the access phase.
    if (apb_setup)
    begin
      nxt.prdata = 32'h0000_0000;
      if (hit_ptr)
      begin
        nxt.prdata = {16'h0000, cur.ptr};
      end
      else if (hit_flags)
      begin
        nxt.prdata = {24'h00_0000, cur.flags | PCF_FLG_ONES}; // RL6
      end
      else if (hit_status)
      begin
        nxt.prdata = {28'h000_0000, cur.inhibit, running, cur.state};
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      cur.state   <= PCF_ST_VEC_HI;
      cur.ptr     <= 16'h0000;
      cur.vec_hi  <= 8'h00;
      cur.flags   <= PCF_FLG_RESET;
      cur.inhibit <= 1'b0;
      cur.prdata  <= 32'h0000_0000;
      cur.alu_res <= 8'h00;
    end
    else
    begin
      cur <= nxt;
    end
  end

  assign O_PRDATA             = cur.prdata;
  assign O_PREADY             = 1'b1;
  assign O_PSLVERR            = apb_access && !(hit_ptr || hit_flags || hit_status);
  assign O_VEC_REQ            = !running;
  assign O_VEC_ADDR           = (cur.state == PCF_ST_VEC_LO) ? PCF_VEC_LO_ADDR : PCF_VEC_HI_ADDR;
  assign O_NEXT_FETCH_POINTER = cur.ptr;
  assign O_CPU_RUN            = running;
  assign O_ALU_RESULT         = cur.alu_res;
  assign O_CONDITION_FLAGS    = cur.flags;
  // Maskable interrupts pass only when unmasked and not held off.
  assign O_IRQ_ACCEPT         = running && I_BOUNDARY && I_IRQ_PENDING && !mask_now
                                && !cur.inhibit; // RL10 RL12

  // Signed branch conditions use negative xor overflow.
  assign O_BRANCH_SIGNED_LESS          = cur.flags[PCF_FLG_N] ^ cur.flags[PCF_FLG_V]; // RL7
  assign O_BRANCH_SIGNED_GREATER_EQUAL = !O_BRANCH_SIGNED_LESS;
  assign O_BRANCH_SIGNED_LESS_EQUAL    = cur.flags[PCF_FLG_Z] || O_BRANCH_SIGNED_LESS;
  assign O_BRANCH_SIGNED_GREATER       = !O_BRANCH_SIGNED_LESS_EQUAL;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  logic quiet_flags;
  assign quiet_flags = !I_FLAGS_WE && !apb_flags_wr && !I_UNMASK_IRQ_INSTR
                       && !I_MASK_IRQ_INSTR && !I_REGS_SAVED;

  sequence s_vec_hi_taken;
    cur.state == PCF_ST_VEC_HI && O_VEC_ADDR == PCF_VEC_HI_ADDR && I_VEC_VALID;
  endsequence

  sequence s_vec_lo_taken;
    cur.state == PCF_ST_VEC_LO && O_VEC_ADDR == PCF_VEC_LO_ADDR && I_VEC_VALID;
  endsequence

  property p_ptr_hold;
    running && !I_FETCH && !I_PTR_LOAD && !apb_ptr_wr |=> $stable(cur.ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without cause"); // RL1

  property p_ptr_incr;
    running && I_FETCH && !I_PTR_LOAD && !apb_ptr_wr
      |=> cur.ptr == $past(cur.ptr) + 16'h0001;
  endproperty
  a_ptr_incr: assert property (p_ptr_incr) else $error("fetch did not advance pointer"); // RL2

  property p_ptr_load;
    running && I_PTR_LOAD |=> cur.ptr == $past(I_PTR_TARGET) && O_CPU_RUN;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("change of flow not loaded"); // RL3

  property p_vec_hi;
    s_vec_hi_taken |=> cur.state == PCF_ST_VEC_LO && cur.vec_hi == $past(I_VEC_DATA);
  endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("vector high byte not kept"); // RL5

  property p_vec_load;
    s_vec_lo_taken |=> running && cur.ptr == {$past(cur.vec_hi), $past(I_VEC_DATA)};
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("reset vector assembled wrong"); // RL4 RL5

  property p_run_stays;
    running |=> running && !O_VEC_REQ;
  endproperty
  a_run_stays: assert property (p_run_stays) else $error("run state left"); // RL4

  property p_ones;
    cur.flags[PCF_FLG_ONE_HI] && cur.flags[PCF_FLG_ONE_LO];
  endproperty
  a_ones: assert property (p_ones) else $error("fixed flag bits not one"); // RL6

  property p_add_flags;
    (I_ALU_OP == PCF_OP_ADD) && quiet_flags
      |=> cur.flags[PCF_FLG_C] == ($past({1'b0, I_ALU_A} + {1'b0, I_ALU_B}) > 9'h0FF)
          && cur.flags[PCF_FLG_H] == ($past({1'b0, I_ALU_A[3:0]} + {1'b0, I_ALU_B[3:0]}) > 5'h0F)
          && cur.flags[PCF_FLG_V] == ($past(I_ALU_A[7]) == $past(I_ALU_B[7])
                                      && $past(I_ALU_A[7]) != O_ALU_RESULT[7]);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong"); // RL7 RL8 RL17

  property p_nz_flags;
    (I_ALU_OP == PCF_OP_LOAD8 || I_ALU_OP == PCF_OP_LOGIC) && quiet_flags
      |=> cur.flags[PCF_FLG_N] == $past(I_ALU_B[7])
          && cur.flags[PCF_FLG_Z] == ($past(I_ALU_B) == 8'h00);
  endproperty
  a_nz_flags: assert property (p_nz_flags) else $error("negative or zero flag wrong"); // RL13 RL14 RL15 RL16

  property p_sub_carry;
    (I_ALU_OP == PCF_OP_SUB) && quiet_flags
      |=> cur.flags[PCF_FLG_C] == ($past(I_ALU_A) < $past(I_ALU_B));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("borrow flag wrong"); // RL17

  property p_bittest_carry;
    (I_ALU_OP == PCF_OP_BITTEST) && quiet_flags |=> cur.flags[PCF_FLG_C] == $past(I_ALU_CARRY);
  endproperty
  a_bittest_carry: assert property (p_bittest_carry) else $error("bit test carry wrong"); // RL18

  property p_flags_write;
    I_FLAGS_WE && !I_UNMASK_IRQ_INSTR && !I_MASK_IRQ_INSTR && !I_REGS_SAVED
      |=> cur.flags == ($past(I_FLAGS_WDATA) | PCF_FLG_ONES);
  endproperty
  a_flags_write: assert property (p_flags_write) else $error("flag transfer wrong"); // RL6

  property p_mask_block;
    mask_now |-> !O_IRQ_ACCEPT;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("interrupt accepted while masked"); // RL10

  property p_entry_mask;
    I_REGS_SAVED |=> cur.flags[PCF_FLG_I] ##0 !O_IRQ_ACCEPT;
  endproperty
  a_entry_mask: assert property (p_entry_mask) else $error("entry did not set mask"); // RL11

  sequence s_unmask_step;
    mask_now && I_UNMASK_IRQ_INSTR && !I_MASK_IRQ_INSTR && !I_REGS_SAVED;
  endsequence

  property p_unmask_holdoff;
    s_unmask_step |=> cur.inhibit && !O_IRQ_ACCEPT;
  endproperty
  a_unmask_holdoff: assert property (p_unmask_holdoff) else $error("interrupt after unmask"); // RL12

  property p_holdoff_keep;
    cur.inhibit && !I_BOUNDARY |=> cur.inhibit && !O_IRQ_ACCEPT;
  endproperty
  a_holdoff_keep: assert property (p_holdoff_keep) else $error("hold-off dropped early"); // RL12

endmodule // pcf_core

// ==== core/pcf_pkg.sv ====
// Constants and types for the next-fetch pointer and condition flag block.
// Assumes a single 200 MHz clock domain and an APB master on the same clock.
// How it works
// RL1 - A 16-bit pointer always holds the address of the next byte fetched.
// RL2 - Each instruction or operand byte fetch advances the pointer by one.
// RL3 - Jump, branch, interrupt entry and return load a target address instead.
// RL4 - Out of reset the pointer is loaded from the vector at the top locations.
// RL5 - Vector high byte comes from the lower address, low byte from the higher.
// RL6 - The flag register is eight bits and bits six and five always read one.
// RL7 - Bit seven is overflow from two's complement results; signed branches test it.
// RL8 - Bit four records a carry from bit three into bit four on adds.
// RL9 - Decimal adjust corrects a prior add result using half-carry and carry.
// RL10 - Bit three masks every maskable interrupt while it is one.
// RL11 - Interrupt entry sets the mask after registers are stacked, before service code.
// RL12 - No interrupt is taken at the boundary after an instruction clearing the mask.
// RL13 - Bit two copies result bit seven after arithmetic, logic or data moves.
// RL14 - Loading or storing a value sets the negative flag from its top bit.
// RL15 - Bit one is set when an 8-bit or 16-bit result is all zeros.
// RL16 - Loading or storing a value sets the zero flag when it is all zeros.
// RL17 - Bit zero is set on carry out of bit seven or borrow on subtract.
// RL18 - Bit test, shift and rotate operations also set or clear the carry.
package pcf_pkg;

  localparam int          PCF_PTR_W       = 16;
  localparam int          PCF_DAT_W       = 8;
  localparam logic [15:0] PCF_VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] PCF_VEC_LO_ADDR = 16'hFFFF;

  // Flag bit positions.
  localparam int          PCF_FLG_V       = 7;
  localparam int          PCF_FLG_ONE_HI  = 6;
  localparam int          PCF_FLG_ONE_LO  = 5;
  localparam int          PCF_FLG_H       = 4;
  localparam int          PCF_FLG_I       = 3;
  localparam int          PCF_FLG_N       = 2;
  localparam int          PCF_FLG_Z       = 1;
  localparam int          PCF_FLG_C       = 0;
  localparam logic [7:0]  PCF_FLG_ONES    = 8'h60;
  localparam logic [7:0]  PCF_FLG_RESET   = 8'h68;

  // Decimal adjust corrections and limits.
  localparam logic [7:0]  PCF_DEC_LO_FIX  = 8'h06;
  localparam logic [7:0]  PCF_DEC_HI_FIX  = 8'h60;
  localparam logic [3:0]  PCF_BCD_DIGIT   = 4'h9;
  localparam logic [7:0]  PCF_BCD_BYTE    = 8'h99;

  // APB register byte offsets.
  localparam logic [11:0] PCF_OFS_PTR     = 12'h000;
  localparam logic [11:0] PCF_OFS_FLAGS   = 12'h004;
  localparam logic [11:0] PCF_OFS_STATUS  = 12'h008;

  typedef enum logic [3:0] {
    PCF_OP_NONE    = 4'h0,
    PCF_OP_ADD     = 4'h1,
    PCF_OP_ADC     = 4'h2,
    PCF_OP_SUB     = 4'h3,
    PCF_OP_SBC     = 4'h4,
    PCF_OP_LOGIC   = 4'h5,
    PCF_OP_LOAD8   = 4'h6,
    PCF_OP_LOAD16  = 4'h7,
    PCF_OP_SHIFT   = 4'h8,
    PCF_OP_BITTEST = 4'h9,
    PCF_OP_DEC_ADJ = 4'hA
  } pcf_op_t;

  typedef enum logic [1:0] {
    PCF_ST_VEC_HI = 2'b00,
    PCF_ST_VEC_LO = 2'b01,
    PCF_ST_RUN    = 2'b11
  } pcf_state_t;

  typedef struct packed {
    pcf_state_t  state;
    logic [15:0] ptr;
    logic [7:0]  vec_hi;
    logic [7:0]  flags;
    logic        inhibit;
    logic [31:0] prdata;
    logic [7:0]  alu_res;
  } pcf_core_st_t;

endpackage

// ==== core/pcf_flag_calc.sv ====
// Combinational result and flag evaluation for one ALU operation.
// Assumes operands are stable from same-clock CPU logic.
`timescale 1ns/1ps
module pcf_flag_calc
  import pcf_pkg::*;
(
  // Operation and operands.
  input  wire logic [3:0]  i_op,
  input  wire logic [7:0]  i_a,
  input  wire logic [7:0]  i_b,
  input  wire logic [15:0] i_wide,
  input  wire logic        i_carry,
  // Current flags.
  input  wire logic [7:0]  i_flags,
  // Result, flag values and update mask.
  output logic      [7:0]  o_res,
  output logic      [7:0]  o_val,
  output logic      [7:0]  o_upd
);

  logic [8:0] sum;
  logic [4:0] half;
  logic       cin;
  logic       lo_fix;
  logic       hi_fix;

  always_comb
  begin
    cin    = (i_op == PCF_OP_ADC || i_op == PCF_OP_SBC) ? i_flags[PCF_FLG_C] : 1'b0;
    sum    = 9'h000;
    half   = 5'h00;
    lo_fix = 1'b0;
    hi_fix = 1'b0;
    o_res  = i_b;
    o_val  = 8'h00;
    o_upd  = 8'h00;
    case (i_op)
      PCF_OP_ADD, PCF_OP_ADC:
      begin
        sum   = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
        half  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
        o_res = sum[7:0];
        o_val[PCF_FLG_V] = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]); // RL7
        o_val[PCF_FLG_H] = half[4]; // RL8
        o_val[PCF_FLG_C] = sum[8]; // RL17
        o_upd = 8'h97;
      end
      PCF_OP_SUB, PCF_OP_SBC:
      begin
        sum   = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cin};
        o_res = sum[7:0];
        o_val[PCF_FLG_V] = (i_a[7] != i_b[7]) && (sum[7] != i_a[7]); // RL7
        o_val[PCF_FLG_C] = sum[8]; // RL17
        o_upd = 8'h87;
      end
      PCF_OP_LOGIC, PCF_OP_LOAD8:
      begin
        o_upd = 8'h86;
      end
      PCF_OP_LOAD16:
      begin
        o_res = i_wide[7:0];
        o_val[PCF_FLG_N] = i_wide[15]; // RL14
        o_val[PCF_FLG_Z] = (i_wide == 16'h0000); // RL15 RL16
        o_upd = 8'h86;
      end
      PCF_OP_SHIFT:
      begin
        o_val[PCF_FLG_V] = i_b[7] ^ i_carry;
        o_val[PCF_FLG_C] = i_carry; // RL18
        o_upd = 8'h87;
      end
      PCF_OP_BITTEST:
      begin
        o_val[PCF_FLG_C] = i_carry; // RL18
        o_upd = 8'h01;
      end
      PCF_OP_DEC_ADJ:
      begin
        lo_fix = i_flags[PCF_FLG_H] || (i_a[3:0] > PCF_BCD_DIGIT); // RL9
        hi_fix = i_flags[PCF_FLG_C] || (i_a > PCF_BCD_BYTE); // RL9
        o_res  = i_a + (lo_fix ? PCF_DEC_LO_FIX : 8'h00) + (hi_fix ? PCF_DEC_HI_FIX : 8'h00);
        o_val[PCF_FLG_C] = hi_fix;
        o_upd = 8'h07;
      end
      default:
      begin
        o_upd = 8'h00;
      end
    endcase
    if (i_op != PCF_OP_LOAD16)
    begin
      o_val[PCF_FLG_N] = o_res[7]; // RL13 RL14
      o_val[PCF_FLG_Z] = (o_res == 8'h00); // RL15 RL16
    end
  end

endmodule // pcf_flag_calc

// ==== testbench/tb.sv ====
// Self-checking bench for the fetch pointer and condition flag block.
// Assumes pcf_pkg and pcf_core are compiled first; one 200 MHz clock.
`timescale 1ns/1ps
module tb;
  import pcf_pkg::*;
  typedef struct packed {
    logic        fetch;
    logic        load;
    logic [15:0] tgt;
    logic [3:0]  op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] wide;
    logic        cy;
    logic        fwe;
    logic [7:0]  fwd;
    logic        msk;
    logic        unm;
    logic        sav;
    logic        bnd;
    logic        pnd;
    logic        vv;
    logic [7:0]  vd;
  } pcf_in_t;
  typedef struct {
    int          sel;
    logic [31:0] val;
    int          due;
  } pcf_note_t;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready, pslverr, vreq, run, acc, gt, ge, le, lt, lt_e;
  logic [15:0] vaddr, ptr, ep;
  logic [7:0]  alu, flags, ef, hi, lo, r;
  logic [31:0] rv;
  pcf_in_t     c, v;
  pcf_note_t   q[$];
  int          cyc, err_total, n_checks;
  integer      seed;

  pcf_core uut (
    .I_SYS_CLK(clk),
    .I_ARST_N(rst_n),
    .I_PSEL(psel),
    .I_PENABLE(pen),
    .I_PWRITE(pwr),
    .I_PADDR(paddr),
    .I_PWDATA(pwdata),
    .O_PRDATA(prdata),
    .O_PREADY(pready),
    .O_PSLVERR(pslverr),
    .O_VEC_REQ(vreq),
    .O_VEC_ADDR(vaddr),
    .I_VEC_VALID(c.vv),
    .I_VEC_DATA(c.vd),
    .I_FETCH(c.fetch),
    .I_PTR_LOAD(c.load),
    .I_PTR_TARGET(c.tgt),
    .O_NEXT_FETCH_POINTER(ptr),
    .O_CPU_RUN(run),
    .I_ALU_OP(c.op),
    .I_ALU_A(c.a),
    .I_ALU_B(c.b),
    .I_ALU_WIDE(c.wide),
    .I_ALU_CARRY(c.cy),
    .O_ALU_RESULT(alu),
    .I_FLAGS_WE(c.fwe),
    .I_FLAGS_WDATA(c.fwd),
    .I_MASK_IRQ_INSTR(c.msk),
    .I_UNMASK_IRQ_INSTR(c.unm),
    .I_REGS_SAVED(c.sav),
    .I_BOUNDARY(c.bnd),
    .I_IRQ_PENDING(c.pnd),
    .O_IRQ_ACCEPT(acc),
    .O_CONDITION_FLAGS(flags),
    .O_BRANCH_SIGNED_GREATER(gt),
    .O_BRANCH_SIGNED_GREATER_EQUAL(ge),
    .O_BRANCH_SIGNED_LESS_EQUAL(le),
    .O_BRANCH_SIGNED_LESS(lt)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The run needs about a hundred cycles; a hang ends here.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] obs(input int sel);
    case (sel)
      0: obs = {24'h0, flags};
      1: obs = {16'h0, ptr};
      2: obs = prdata;
      3: obs = {31'h0, acc};
      4: obs = {24'h0, alu};
      5: obs = {28'h0, gt, ge, le, lt};
      6: obs = {31'h0, pslverr};
      7: obs = {14'h0, run, vreq, vaddr};
      default: obs = {30'h0, run, vreq};
    endcase
  endfunction

  // Each note names an output and the cycle at which it must show the value.
  always @(negedge clk)
    for (int i = q.size() - 1; i >= 0; i--)
      if (q[i].due <= cyc)
      begin
        check(obs(q[i].sel), q[i].val);
        q.delete(i);
      end

  task automatic note(input int sel, input logic [31:0] val, input int dly);
    q.push_back('{sel, val, cyc + dly});
  endtask

  task automatic go(input pcf_in_t x);
    @(posedge clk);
    c <= x;
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     input logic err, input logic [31:0] exp);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    note(6, {31'h0, err}, 1);
    if (!wr)
      note(2, exp, 1);
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic alu_model(input pcf_in_t x);
    logic [8:0] s;
    logic       ci;
    ci = (x.op == PCF_OP_ADC || x.op == PCF_OP_SBC) ? ef[0] : 1'b0;
    r = x.b;
    case (x.op)
      PCF_OP_ADD, PCF_OP_ADC:
      begin
        s = {1'b0, x.a} + {1'b0, x.b} + {8'h0, ci};
        r = s[7:0];
        ef[4] = ({1'b0, x.a[3:0]} + {1'b0, x.b[3:0]} + {4'h0, ci}) > 5'hF;
        ef[7] = (x.a[7] == x.b[7]) && (r[7] != x.a[7]);
        ef[0] = s[8];
      end
      PCF_OP_SUB, PCF_OP_SBC:
      begin
        s = {1'b0, x.a} - {1'b0, x.b} - {8'h0, ci};
        r = s[7:0];
        ef[7] = (x.a[7] != x.b[7]) && (r[7] != x.a[7]);
        ef[0] = s[8];
      end
      PCF_OP_SHIFT:
      begin
        ef[0] = x.cy;
        ef[7] = x.b[7] ^ x.cy;
      end
      PCF_OP_BITTEST: ef[0] = x.cy;
      PCF_OP_DEC_ADJ:
      begin
        s = {1'b0, x.a} + ((ef[4] || x.a[3:0] > 4'h9) ? 9'h006 : 9'h000)
          + ((ef[0] || x.a > 8'h99) ? 9'h060 : 9'h000);
        r = s[7:0];
        ef[0] = ef[0] || x.a > 8'h99;
      end
      default: ef[7] = 1'b0;
    endcase
    if (x.op != PCF_OP_BITTEST)
    begin
      ef[2] = (x.op == PCF_OP_LOAD16) ? x.wide[15] : r[7];
      ef[1] = (x.op == PCF_OP_LOAD16) ? (x.wide == 16'h0) : (r == 8'h0);
    end
  endtask

  // First boundary after the mask clears is refused, the next one accepts.
  task automatic irq_pair();
    pcf_in_t b;
    b = '0;
    b.bnd = 1'b1;
    b.pnd = 1'b1;
    go(b);
    note(3, 32'h0, 1);
    go(b);
    note(3, 32'h1, 1);
    go('0);
  endtask

  initial
  begin
    c = '0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rst_n = 1'b0;
    err_total = 0;
    n_checks = 0;
    seed = 32'h0A61;
    ef = 8'h68;
    repeat (10) @(posedge clk);
    note(0, 32'h68, 1);
    note(7, 32'h1FFFE, 1);
    note(3, 32'h0, 1);
    rst_n <= 1'b1;
    hi = 8'($random(seed));
    lo = 8'($random(seed));
    v = '0;
    v.fetch = 1'b1;
    go(v);
    go(v);
    v = '0;
    v.vv = 1'b1;
    v.vd = hi;
    go(v);
    note(7, 32'h1FFFE, 1);
    note(1, 32'h0, 1);
    go('0);
    go('0);
    v.vd = lo;
    go(v);
    note(7, 32'h1FFFF, 1);
    go('0);
    note(8, 32'h2, 1);
    note(1, {16'h0, hi, lo}, 1);
    ep = {hi, lo};
    v = '0;
    v.fetch = 1'b1;
    repeat (4 + ($random(seed) & 3))
    begin
      go(v);
      ep = ep + 16'h1;
      note(1, {16'h0, ep}, 2);
    end
    v.load = 1'b1;
    v.tgt = 16'hFFFF;
    go(v);
    note(1, 32'hFFFF, 2);
    v.load = 1'b0;
    go(v);
    note(1, 32'h0, 2);
    go('0);
    rv = 32'($random(seed));
    ep = rv[15:0];
    apb(1'b1, 12'h000, rv, 1'b0, 32'h0);
    apb(1'b0, 12'h000, 32'h0, 1'b0, {16'h0, ep});
    for (int i = 0; i < 30; i++)
    begin
      v = '0;
      v.op = 4'(1 + i % 10);
      v.a = 8'($random(seed));
      v.b = 8'($random(seed));
      v.wide = 16'($random(seed));
      v.cy = 1'($random(seed));
      go(v);
      alu_model(v);
      lt_e = ef[2] ^ ef[7];
      note(0, {24'h0, ef}, 2);
      note(5, {28'h0, !(ef[1] | lt_e), !lt_e, ef[1] | lt_e, lt_e}, 2);
      if (v.op != PCF_OP_LOAD16 && v.op != PCF_OP_BITTEST)
        note(4, {24'h0, r}, 2);
    end
    v = '0;
    v.bnd = 1'b1;
    v.pnd = 1'b1;
    go(v);
    note(3, 32'h0, 1);
    v = '0;
    v.unm = 1'b1;
    go(v);
    ef[3] = 1'b0;
    note(0, {24'h0, ef}, 2);
    irq_pair();
    v = '0;
    v.sav = 1'b1;
    go(v);
    ef[3] = 1'b1;
    note(0, {24'h0, ef}, 2);
    v = '0;
    v.bnd = 1'b1;
    v.pnd = 1'b1;
    go(v);
    note(3, 32'h0, 1);
    v = '0;
    v.fwe = 1'b1;
    v.fwd = 8'($random(seed)) & 8'hF7;
    go(v);
    ef = v.fwd | 8'h60;
    note(0, {24'h0, ef}, 2);
    irq_pair();
    v = '0;
    v.msk = 1'b1;
    go(v);
    ef[3] = 1'b1;
    note(0, {24'h0, ef}, 2);
    go('0);
    rv = 32'($random(seed)) | 32'h8;
    apb(1'b1, 12'h004, rv, 1'b0, 32'h0);
    ef = rv[7:0] | 8'h60;
    note(0, {24'h0, ef}, 1);
    apb(1'b0, 12'h004, 32'h0, 1'b0, {24'h0, ef});
    apb(1'b0, 12'h008, 32'h0, 1'b0, 32'h7);
    apb(1'b1, 12'h010, rv, 1'b1, 32'h0);
    apb(1'b0, 12'h00C, 32'h0, 1'b1, 32'h0);
    apb(1'b0, 12'h000, 32'h0, 1'b0, {16'h0, ep});
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule // tb
